// >>> crystal_prescaler.sv
`timescale 1ns/1ps
`default_nettype none

module crystal_prescaler
    import interval_timekeeper_pkg::*;
#(
    parameter int EDGES_PER_TICK = XTAL_EDGES_PER_FRACTION
)
(
    input  wire logic        i_clk_sys,
    input  wire logic        i_resetn,
    input  wire logic        i_xtal_32k,
    input  wire logic        i_run,
    fraction_tick_if.src     tick_port
);

    initial
    begin
        if (EDGES_PER_TICK < 2 || EDGES_PER_TICK > 65536)
            $error("crystal_prescaler: EDGES_PER_TICK out of range");
    end

    typedef struct packed {
        logic        sync_a;
        logic        sync_b;
        logic        last_level;
        logic [15:0] edge_count;
        logic        tick;
    } prescale_state_t;

    localparam logic [15:0] LAST_EDGE = 16'(EDGES_PER_TICK - 1);

    prescale_state_t state;
    prescale_state_t next_state;

    ////////////////////////////////////////////////////////////////////////////

    always_comb
    begin
        next_state            = state;
        next_state.sync_a     = i_xtal_32k;
        next_state.sync_b     = state.sync_a;
        next_state.last_level = state.sync_b;
        next_state.tick       = 1'b0;
        // The count is held at zero while stopped so each start begins a full tick.
        if (!i_run)
        begin
            next_state.edge_count = 16'h0000;
        end
        else if (state.sync_b && !state.last_level)
        begin
            if (state.edge_count == LAST_EDGE)
            begin
                next_state.edge_count = 16'h0000;
                next_state.tick       = 1'b1;
            end
            else
            begin
                next_state.edge_count = state.edge_count + 16'h0001;
            end
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_resetn)
    begin
        if (!i_resetn)
            state <= '0;
        else
            state <= next_state;
    end

    assign tick_port.tick = state.tick;

endmodule : crystal_prescaler

`default_nettype wire

// >>> fraction_tick_if.sv
`timescale 1ns/1ps
`default_nettype none

interface fraction_tick_if;
    logic tick;
    modport src (output tick);
    modport dst (input tick);
endinterface : fraction_tick_if

`default_nettype wire

// >>> interval_timekeeper.sv
// How it works
// - Time counters advance from the crystal, also during power-down.
// - Two-bit base field picks the fraction tick or the fraction, second or minute overflow.
// - The interval counter advances once per increment of the chosen time counter.
// - Counter equal to target sets the match flag and requests an interrupt.
// - Enabled match flag in power-down raises the wake output.
// - Single-shot timeout clears interval enable; otherwise counter restarts.
// - Match flag stays set until software writes a zero.
// - Interval counter runs only while interval enable is set.
// - Clock enable gates time counting; clearing restores last written time.
// - Time registers accept writes only while clock enable is low.
// - Day wrap bit selects hour wrap after 23 or after 255.
// - Fraction counts 0 to 127 per 1/128 s, then carries into seconds.
// - Seconds count 0 to 59, then carry into minutes.
// - Minutes count 0 to 59, then carry into hours.
// - In day mode hours count 0 to 23 and roll to zero.
// - Control bit 7 is not stored and reads zero.
// - Reset clears control, target and all time registers.
`timescale 1ns/1ps
`default_nettype none

module interval_timekeeper
    import interval_timekeeper_pkg::*;
#(
    parameter int EDGES_PER_TICK = XTAL_EDGES_PER_FRACTION
)
(
    input  wire logic       i_clk_sys,
    input  wire logic       i_resetn,
    input  wire logic       i_xtal_32k,
    input  wire logic       i_power_down,
    input  wire logic       i_irq_enable,
    input  wire logic [7:0] i_sfr_addr,
    input  wire logic       i_sfr_wr,
    input  wire logic [7:0] i_sfr_wdata,
    output logic      [7:0] o_sfr_rdata,
    output logic            o_irq,
    output logic            o_wake
);

    typedef struct packed {
        logic           day_wrap_select;
        interval_base_t base_select;
        logic           single_shot_select;
        logic           interval_match_flag;
        logic           interval_count_enable;
        logic           timekeeping_clock_enable;
        logic [7:0]     fraction_tick_count;
        logic [7:0]     unit_s_count;
        logic [7:0]     sixty_s_count;
        logic [7:0]     hour_count;
        logic [7:0]     fraction_written;
        logic [7:0]     unit_s_written;
        logic [7:0]     sixty_s_written;
        logic [7:0]     hour_written;
        logic [7:0]     interval_target;
        logic [7:0]     interval_count;
        logic [7:0]     rdata;
        logic           irq;
        logic           wake;
    } keeper_state_t;

    keeper_state_t state;
    keeper_state_t next_state;

    fraction_tick_if tick_bus ();

    logic           fraction_ovf;
    logic           second_ovf;
    logic           minute_ovf;
    logic           base_ovf;
    logic [7:0]     hour_last;
    logic [7:0]     interval_next;
    logic           timeout;
    logic           wr_control;
    logic           time_writable;

    ////////////////////////////////////////////////////////////////////////////

    function automatic logic [7:0] wrap_step(input logic [7:0] value, input logic [7:0] last);
        wrap_step = (value >= last) ? 8'h00 : value + 8'h01;
    endfunction : wrap_step

    function automatic logic [7:0] read_control(input keeper_state_t s);
        logic [7:0] v;
        v = 8'h00;
        v[BIT_DAY_WRAP_SELECT]          = s.day_wrap_select;
        v[BIT_INTERVAL_BASE_SELECT_HI]  = s.base_select[1];
        v[BIT_INTERVAL_BASE_SELECT_LO]  = s.base_select[0];
        v[BIT_SINGLE_SHOT_SELECT]       = s.single_shot_select;
        v[BIT_INTERVAL_MATCH_FLAG]      = s.interval_match_flag;
        v[BIT_INTERVAL_COUNT_ENABLE]    = s.interval_count_enable;
        v[BIT_TIMEKEEPING_CLOCK_ENABLE] = s.timekeeping_clock_enable;
        read_control = v;
    endfunction : read_control

    ////////////////////////////////////////////////////////////////////////////

    crystal_prescaler #(
        .EDGES_PER_TICK (EDGES_PER_TICK)
    ) u_prescaler (
        .i_clk_sys  (i_clk_sys),
        .i_resetn   (i_resetn),
        .i_xtal_32k (i_xtal_32k),
        .i_run      (state.timekeeping_clock_enable),
        .tick_port  (tick_bus.src)
    );

    ////////////////////////////////////////////////////////////////////////////

    always_comb
    begin
        hour_last = state.day_wrap_select ? LAST_HOUR_DAY : LAST_HOUR_FULL;

        fraction_ovf = tick_bus.tick && state.timekeeping_clock_enable
                       && (state.fraction_tick_count >= LAST_FRACTION);
        second_ovf   = fraction_ovf && (state.unit_s_count >= LAST_SECOND);
        minute_ovf   = second_ovf && (state.sixty_s_count >= LAST_MINUTE);

        // timebase select
        // Each base above the fraction tick is the carry out of the register below it, so a seconds base counts seconds.
        unique case (state.base_select)
            BASE_FRACTION: base_ovf = tick_bus.tick && state.timekeeping_clock_enable;
            BASE_SECOND:   base_ovf = fraction_ovf;
            BASE_MINUTE:   base_ovf = second_ovf;
            BASE_HOUR:     base_ovf = minute_ovf;
        endcase

        interval_next = state.interval_count + 8'h01;
        timeout = base_ovf && state.interval_count_enable && (interval_next == state.interval_target);

        wr_control    = i_sfr_wr && (i_sfr_addr == ADDR_INTERVAL_CONTROL);
        time_writable = i_sfr_wr && !state.timekeeping_clock_enable;
    end

    always_comb
    begin
        next_state = state;

        if (tick_bus.tick && state.timekeeping_clock_enable)
        begin
            next_state.fraction_tick_count = wrap_step(state.fraction_tick_count, LAST_FRACTION);
        end
        if (fraction_ovf)
            next_state.unit_s_count = wrap_step(state.unit_s_count, LAST_SECOND);
        if (second_ovf)
            next_state.sixty_s_count = wrap_step(state.sixty_s_count, LAST_MINUTE);
        if (minute_ovf)
            next_state.hour_count = wrap_step(state.hour_count, hour_last);

        if (!state.timekeeping_clock_enable)
        begin
            next_state.fraction_tick_count = state.fraction_written;
            next_state.unit_s_count        = state.unit_s_written;
            next_state.sixty_s_count       = state.sixty_s_written;
            next_state.hour_count          = state.hour_written;
        end

        if (time_writable && i_sfr_addr == ADDR_FRACTION_TICK_COUNT)
        begin
            next_state.fraction_written    = i_sfr_wdata;
            next_state.fraction_tick_count = i_sfr_wdata;
        end
        if (time_writable && i_sfr_addr == ADDR_UNIT_S_COUNT)
        begin
            next_state.unit_s_written = i_sfr_wdata;
            next_state.unit_s_count   = i_sfr_wdata;
        end
        if (time_writable && i_sfr_addr == ADDR_SIXTY_S_COUNT)
        begin
            next_state.sixty_s_written = i_sfr_wdata;
            next_state.sixty_s_count   = i_sfr_wdata;
        end
        if (time_writable && i_sfr_addr == ADDR_HOUR_COUNT)
        begin
            next_state.hour_written = i_sfr_wdata;
            next_state.hour_count   = i_sfr_wdata;
        end
        if (i_sfr_wr && i_sfr_addr == ADDR_INTERVAL_TARGET)
            next_state.interval_target = i_sfr_wdata;

        if (base_ovf && state.interval_count_enable)
            next_state.interval_count = interval_next;

        if (timeout)
        begin
            next_state.interval_count = 8'h00;
            if (state.single_shot_select)
                next_state.interval_count_enable = 1'b0;
        end

        if (wr_control)
        begin
            next_state.day_wrap_select          = i_sfr_wdata[BIT_DAY_WRAP_SELECT];
            next_state.base_select              = interval_base_t'({i_sfr_wdata[BIT_INTERVAL_BASE_SELECT_HI],
                                                                    i_sfr_wdata[BIT_INTERVAL_BASE_SELECT_LO]});
            next_state.single_shot_select       = i_sfr_wdata[BIT_SINGLE_SHOT_SELECT];
            next_state.interval_count_enable    = i_sfr_wdata[BIT_INTERVAL_COUNT_ENABLE];
            next_state.timekeeping_clock_enable = i_sfr_wdata[BIT_TIMEKEEPING_CLOCK_ENABLE];
            if (!i_sfr_wdata[BIT_INTERVAL_MATCH_FLAG])
                next_state.interval_match_flag = 1'b0;
        end

        if (timeout)
            next_state.interval_match_flag = 1'b1;

        if (!next_state.interval_count_enable)
            next_state.interval_count = 8'h00;

        next_state.irq  = next_state.interval_match_flag && i_irq_enable;
        next_state.wake = next_state.interval_match_flag && i_irq_enable && i_power_down;

        unique case (i_sfr_addr)
            ADDR_INTERVAL_CONTROL:    next_state.rdata = read_control(state);
            ADDR_FRACTION_TICK_COUNT: next_state.rdata = state.fraction_tick_count;
            ADDR_UNIT_S_COUNT:        next_state.rdata = state.unit_s_count;
            ADDR_SIXTY_S_COUNT:       next_state.rdata = state.sixty_s_count;
            ADDR_HOUR_COUNT:          next_state.rdata = state.hour_count;
            ADDR_INTERVAL_TARGET:     next_state.rdata = state.interval_target;
            default:                  next_state.rdata = READ_UNMAPPED;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////

    always_ff @(posedge i_clk_sys or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            state <= '0;
            state.interval_target <= RESET_INTERVAL_TARGET;
            state.rdata           <= READ_UNMAPPED;
        end
        else
        begin
            state <= next_state;
        end
    end

    assign o_sfr_rdata = state.rdata;
    assign o_irq       = state.irq;
    assign o_wake      = state.wake;

endmodule : interval_timekeeper

`default_nettype wire

// >>> interval_timekeeper_chk.sv
`timescale 1ns/1ps
`default_nettype none

module interval_timekeeper_chk
    import interval_timekeeper_pkg::*;
#(
    parameter int EDGES_PER_TICK = XTAL_EDGES_PER_FRACTION
)
(
    input  wire logic       i_clk_sys,
    input  wire logic       i_resetn,
    input  wire logic       i_xtal_32k,
    input  wire logic       i_power_down,
    input  wire logic       i_irq_enable,
    input  wire logic [7:0] i_sfr_addr,
    input  wire logic       i_sfr_wr,
    input  wire logic [7:0] i_sfr_wdata,
    input  wire logic [7:0] o_sfr_rdata,
    input  wire logic       o_irq,
    input  wire logic       o_wake
);
    logic clk_on;
    logic time_addr;
    logic ctrl_wr;

    assign time_addr = (i_sfr_addr >= ADDR_FRACTION_TICK_COUNT)
                    && (i_sfr_addr <= ADDR_HOUR_COUNT);
    assign ctrl_wr   = i_sfr_wr && (i_sfr_addr == ADDR_INTERVAL_CONTROL);

    // The clock enable is mirrored from control writes, as the checker cannot see inside.
    always_ff @(posedge i_clk_sys or negedge i_resetn)
    begin
        if (!i_resetn)
            clk_on <= 1'b0;
        else if (ctrl_wr)
            clk_on <= i_sfr_wdata[BIT_TIMEKEEPING_CLOCK_ENABLE];
    end

    default clocking main_cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_resetn);

    ////////////////////////////////////////////////////////////////////////////////
    wake_needs_irq_a: assert property (o_wake |-> o_irq)
        else $error("Wake seen without an interrupt request.");
    wake_needs_pd_a: assert property (!i_power_down |=> !o_wake)
        else $error("Wake seen outside power-down.");
    irq_masked_a: assert property (!i_irq_enable |=> !o_irq)
        else $error("Interrupt raised while disabled.");
    flag_sticky_a: assert property (o_irq && i_irq_enable && !ctrl_wr |=> o_irq)
        else $error("Match flag dropped without a software clear.");
    bit7_zero_a: assert property (i_sfr_addr == ADDR_INTERVAL_CONTROL |=> !o_sfr_rdata[7])
        else $error("Control bit 7 read as one.");
    target_readback_a: assert property ((i_sfr_wr && i_sfr_addr == ADDR_INTERVAL_TARGET)
        ##1 (i_sfr_addr == ADDR_INTERVAL_TARGET) |=> o_sfr_rdata == $past(i_sfr_wdata, 2))
        else $error("Target read back differs from the value written.");
    time_write_a: assert property ((i_sfr_wr && time_addr && !clk_on) ##1 $stable(i_sfr_addr)
        |=> o_sfr_rdata == $past(i_sfr_wdata, 2))
        else $error("Time write with the clock off was not taken.");
    time_frozen_a: assert property (!clk_on && time_addr && $stable(i_sfr_addr)
        && !$past(i_sfr_wr) && !$past(i_sfr_wr, 2) |=> $stable(o_sfr_rdata))
        else $error("Time register moved while the clock was off.");

    irq_seen_c: cover property ($rose(o_irq));
    wake_seen_c: cover property ($rose(o_wake));
    time_write_c: cover property (i_sfr_wr && time_addr && !clk_on);

endmodule : interval_timekeeper_chk

bind interval_timekeeper interval_timekeeper_chk #(.EDGES_PER_TICK(EDGES_PER_TICK)) chk_u
(
    .i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_xtal_32k(i_xtal_32k),
    .i_power_down(i_power_down), .i_irq_enable(i_irq_enable), .i_sfr_addr(i_sfr_addr),
    .i_sfr_wr(i_sfr_wr), .i_sfr_wdata(i_sfr_wdata), .o_sfr_rdata(o_sfr_rdata),
    .o_irq(o_irq), .o_wake(o_wake)
);

`default_nettype wire

// >>> interval_timekeeper_pkg.sv
package interval_timekeeper_pkg;

    // Special-function register addresses.
    localparam logic [7:0] ADDR_INTERVAL_CONTROL     = 8'hA1;
    localparam logic [7:0] ADDR_FRACTION_TICK_COUNT  = 8'hA2;
    localparam logic [7:0] ADDR_UNIT_S_COUNT         = 8'hA3;
    localparam logic [7:0] ADDR_SIXTY_S_COUNT        = 8'hA4;
    localparam logic [7:0] ADDR_HOUR_COUNT           = 8'hA5;
    localparam logic [7:0] ADDR_INTERVAL_TARGET      = 8'hA6;

    // Control register field positions.
    localparam int BIT_TIMEKEEPING_CLOCK_ENABLE = 0;
    localparam int BIT_INTERVAL_COUNT_ENABLE    = 1;
    localparam int BIT_INTERVAL_MATCH_FLAG      = 2;
    localparam int BIT_SINGLE_SHOT_SELECT       = 3;
    localparam int BIT_INTERVAL_BASE_SELECT_LO  = 4;
    localparam int BIT_INTERVAL_BASE_SELECT_HI  = 5;
    localparam int BIT_DAY_WRAP_SELECT          = 6;

    // Power-on values.
    localparam logic [7:0] RESET_INTERVAL_CONTROL = 8'h00;
    localparam logic [7:0] RESET_TIME_COUNT       = 8'h00;
    localparam logic [7:0] RESET_INTERVAL_TARGET  = 8'h00;
    localparam logic [7:0] READ_UNMAPPED          = 8'h00;

    // Counter limits.
    localparam logic [7:0] LAST_FRACTION  = 8'h7F;
    localparam logic [7:0] LAST_SECOND    = 8'h3B;
    localparam logic [7:0] LAST_MINUTE    = 8'h3B;
    localparam logic [7:0] LAST_HOUR_DAY  = 8'h17;
    localparam logic [7:0] LAST_HOUR_FULL = 8'hFF;

    // Crystal rate and the fraction tick rate derived from it.
    localparam int XTAL_HZ     = 32768;
    localparam int FRACTION_HZ = 128;
    localparam int XTAL_EDGES_PER_FRACTION = XTAL_HZ / FRACTION_HZ;

    typedef enum logic [1:0]
    {
        BASE_FRACTION,
        BASE_SECOND,
        BASE_MINUTE,
        BASE_HOUR
    } interval_base_t;

endpackage : interval_timekeeper_pkg

// >>> test_interval_timekeeper.sv
`timescale 1ns/1ps
`default_nettype none

module test_interval_timekeeper
    import interval_timekeeper_pkg::*;
;
    logic       clk_sys    = 1'b0;
    logic       resetn     = 1'b0;
    logic       xtal       = 1'b0;
    logic       power_down = 1'b0;
    logic       irq_en     = 1'b1;
    logic [7:0] addr       = 8'h00;
    logic       wr_s       = 1'b0;
    logic [7:0] wdata      = 8'h00;
    logic [7:0] rdata;
    logic       irq;
    logic       wake;
    int         err_count  = 0;
    int         num_checks = 0;
    int         b;

    always #12.5 clk_sys = ~clk_sys;
    // The crystal is far faster than in life to keep the run short; its phase is unrelated.
    always #103 xtal = ~xtal;

    interval_timekeeper #(.EDGES_PER_TICK(2)) dut_u
    (
        .i_clk_sys    (clk_sys),
        .i_resetn     (resetn),
        .i_xtal_32k   (xtal),
        .i_power_down (power_down),
        .i_irq_enable (irq_en),
        .i_sfr_addr   (addr),
        .i_sfr_wr     (wr_s),
        .i_sfr_wdata  (wdata),
        .o_sfr_rdata  (rdata),
        .o_irq        (irq),
        .o_wake       (wake)
    );

    ////////////////////////////////////////////////////////////////////////////////
    task automatic step(input int n);
        repeat (n) @(negedge clk_sys);
    endtask : step

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("Error at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        addr  = a;
        wdata = d;
        wr_s  = 1'b1;
        step(1);
        wr_s  = 1'b0;
        step(1);
    endtask : wr

    // Two cycles with the address held, so the read data has settled.
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        addr = a;
        step(2);
        chk(rdata, exp);
    endtask : rd

    task automatic wait_irq(input logic hit);
        int n;
        n = 0;
        while (irq !== 1'b1 && n < 40)
        begin
            step(1);
            n++;
        end
        chk({7'h00, irq}, {7'h00, hit});
    endtask : wait_irq

    // Hours are loaded with the clock off, then the cascade is run over one carry.
    task automatic roll(input logic [7:0] c, input logic [7:0] h, input logic [7:0] eh);
        int n;
        wr(ADDR_INTERVAL_CONTROL, c & 8'hFE);
        wr(ADDR_HOUR_COUNT, h);
        wr(ADDR_INTERVAL_CONTROL, c);
        addr = ADDR_FRACTION_TICK_COUNT;
        n = 0;
        step(1);
        while (rdata !== 8'h00 && n < 40)
        begin
            step(1);
            n++;
        end
        chk(rdata, 8'h00);
        rd(ADDR_UNIT_S_COUNT, 8'h00);
        rd(ADDR_SIXTY_S_COUNT, 8'h00);
        rd(ADDR_HOUR_COUNT, eh);
        wr(ADDR_INTERVAL_CONTROL, c & 8'hFE);
    endtask : roll

    // Preload level p puts the lowest p time counters, from the fraction up, at their last value.
    task automatic run_iv(input logic [7:0] c, input int p, input logic hit);
        wr(ADDR_INTERVAL_CONTROL, c & 8'hFC);
        wr(ADDR_FRACTION_TICK_COUNT, (p > 0) ? 8'h7F : 8'h00);
        wr(ADDR_UNIT_S_COUNT, (p > 1) ? 8'h3B : 8'h00);
        wr(ADDR_SIXTY_S_COUNT, (p > 2) ? 8'h3B : 8'h00);
        wr(ADDR_HOUR_COUNT, 8'h00);
        wr(ADDR_INTERVAL_TARGET, 8'h01);
        wr(ADDR_INTERVAL_CONTROL, c);
        wait_irq(hit);
    endtask : run_iv

    task automatic close_out();
        $display("Checks %0d, errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : close_out

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        step(8);
        resetn = 1'b1;
        step(1);
        for (b = 8'hA1; b <= 8'hA7; b++)
            rd(b[7:0], 8'h00);
        wr(ADDR_INTERVAL_CONTROL, 8'hFC);
        rd(ADDR_INTERVAL_CONTROL, 8'h78);
        wr(ADDR_INTERVAL_CONTROL, 8'h40);
        wr(ADDR_FRACTION_TICK_COUNT, 8'h7F);
        wr(ADDR_UNIT_S_COUNT, 8'h3B);
        wr(ADDR_SIXTY_S_COUNT, 8'h3B);
        rd(ADDR_SIXTY_S_COUNT, 8'h3B);
        roll(8'h41, 8'h17, 8'h00);
        rd(ADDR_FRACTION_TICK_COUNT, 8'h7F);
        roll(8'h01, 8'h17, 8'h18);
        roll(8'h01, 8'hFF, 8'h00);
        wr(ADDR_INTERVAL_CONTROL, 8'h41);
        wr(ADDR_UNIT_S_COUNT, 8'h05);
        wr(ADDR_INTERVAL_CONTROL, 8'h40);
        rd(ADDR_UNIT_S_COUNT, 8'h3B);
        for (b = 0; b < 4; b++)
        begin
            run_iv({2'b01, b[1:0], 4'h3}, b, 1'b1);
            if (b > 0)
                run_iv({2'b01, b[1:0], 4'h3}, b - 1, 1'b0);
        end
        run_iv(8'h4B, 0, 1'b1);
        step(40);
        rd(ADDR_INTERVAL_CONTROL, 8'h4D);
        power_down = 1'b1;
        step(2);
        chk({7'h00, wake}, 8'h01);
        power_down = 1'b0;
        wr(ADDR_INTERVAL_CONTROL, 8'h49);
        chk({7'h00, irq}, 8'h00);
        irq_en = 1'b0;
        run_iv(8'h43, 0, 1'b0);
        rd(ADDR_INTERVAL_CONTROL, 8'h47);
        irq_en = 1'b1;
        wr(ADDR_INTERVAL_CONTROL, 8'h43);
        wait_irq(1'b1);
        run_iv(8'h41, 0, 1'b0);
        rd(ADDR_INTERVAL_CONTROL, 8'h41);
        close_out();
    end

    // The tests need under a thousand cycles; twenty times that means a hang.
    initial
    begin
        repeat (20000) @(posedge clk_sys);
        err_count++;
        close_out();
    end

endmodule : test_interval_timekeeper

`default_nettype wire
